// *** logic/tnsd_defs.svh ***
// Constants for the token network status and diagnostic flag block.
`ifndef TNSD_DEFS_SVH
`define TNSD_DEFS_SVH

// Register byte offsets.
`define TNSD_OFF_STATUS 8'h00
`define TNSD_OFF_DIAG 8'h04
`define TNSD_OFF_CMD 8'h08
`define TNSD_OFF_MASK 8'h0C
`define TNSD_OFF_NODE_ID 8'h10
`define TNSD_OFF_TENT_ID 8'h14
`define TNSD_OFF_NEXT_ID 8'h18
`define TNSD_OFF_CTRL 8'h1C

// Status register bit positions.
`define TNSD_ST_RX_INH 7
`define TNSD_ST_RESET 4
`define TNSD_ST_TEST 3
`define TNSD_ST_REBUILD 2
`define TNSD_ST_TX_ACK 1
`define TNSD_ST_TX_AVAIL 0

// Diagnostic register bit positions.
`define TNSD_DG_SELF_REBUILD 7
`define TNSD_DG_DUP_ID 6
`define TNSD_DG_RX_ACT 5
`define TNSD_DG_TOKEN 4
`define TNSD_DG_EXC_NAK 3
`define TNSD_DG_TENT 2
`define TNSD_DG_NEXT_CHG 1

// Mask register bit positions.
`define TNSD_MK_TX_AVAIL 0
`define TNSD_MK_REBUILD 2
`define TNSD_MK_EXC_NAK 3
`define TNSD_MK_NEXT_CHG 4
`define TNSD_MK_RX_INH 7

// Command codes: low three bits select enable and clear; the disable codes must match the whole byte.
`define TNSD_CMD_DIS_TX 8'h01
`define TNSD_CMD_DIS_RX 8'h02
`define TNSD_CMD_EN_TX 3'h3
`define TNSD_CMD_EN_RX 3'h4
`define TNSD_CMD_CLR_FLAGS 3'h6

// Reset values.
`define TNSD_RST_MASK 8'h00
`define TNSD_RST_ID 8'h00
`define TNSD_RST_CTRL 8'h00

// Timing and counts.
`define TNSD_CLK_PERIOD_NS 40
`define TNSD_IDLE_TIME_NS 656000
`define TNSD_NAK_LIMIT_LONG 8'h80
`define TNSD_NAK_LIMIT_SHORT 8'h04

`endif

// *** logic/tnsd_pkg.sv ***
// Types shared by the token network status and diagnostic flag block.
`default_nettype none
package tnsd_pkg;

  // Pulses from the protocol engine and its timers, one cycle each, except the broadcast and on_line levels.
  typedef struct packed {
    logic token_rx;          // This node received the token.
    logic last_byte_sent;    // Last byte of the scheduled packet left.
    logic ack_rx;            // Destination acknowledged our packet.
    logic broadcast;         // Packet in flight is a broadcast (level).
    logic lost_token_to;     // Lost token timer expired.
    logic nak_rx;            // NAK answered a free buffer enquiry.
    logic enq_ok;            // Free buffer enquiry got a positive answer.
    logic packet_stored;     // A received packet was stored to RAM.
    logic soft_reset;        // Software reset executed.
    logic on_line;           // Transmitter enabled (level).
  } tnsd_evt_t;

  // A token observed on the line.
  typedef struct packed {
    logic seen;              // Token observed, one-cycle pulse.
    logic from_other;        // Sender is another node.
    logic [7:0] dest_id1;    // First destination ID character.
    logic [7:0] dest_id2;    // Second destination ID character.
    logic zeros_ok;          // Trailing zeros checked out.
    logic response;          // A response to this token occurred.
  } tnsd_token_t;

  // Next ID update from the protocol engine.
  typedef struct packed {
    logic valid;             // Update strobe.
    logic [7:0] id;          // New next ID.
  } tnsd_next_t;

endpackage : tnsd_pkg
`default_nettype wire

// *** logic/tnsd_flags.sv ***
// Status and diagnostic flag register bank with APB slave.
//
// Decided for this implementation: the APB register port and the register addresses.
`include "tnsd_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tnsd_flags #(
  parameter int unsigned IDLE_CYCLES = `TNSD_IDLE_TIME_NS / `TNSD_CLK_PERIOD_NS
) (
  input wire logic pclk,                        // Clock, 25 MHz.
  input wire logic presetn,                     // Asynchronous reset, active low.
  input wire logic psel,                        // APB select.
  input wire logic penable,                     // APB enable.
  input wire logic pwrite,                      // APB direction.
  input wire logic [7:0] paddr,                 // APB byte address.
  input wire logic [31:0] pwdata,               // APB write data.
  output logic [31:0] prdata,                   // APB read data.
  output logic pready,                          // APB ready.
  output logic pslverr,                         // APB error on unmapped address.
  input wire tnsd_pkg::tnsd_evt_t evt,          // Protocol engine events.
  input wire tnsd_pkg::tnsd_token_t tok,        // Observed token.
  input wire tnsd_pkg::tnsd_next_t nxt,         // Next ID update.
  input wire logic receive_line_input,          // Receive line pin, asynchronous.
  output logic irq,                             // Interrupt request, active high.
  output logic receiver_inhibited_flag,         // Receiver inhibited: answer with NAK.
  output logic tx_pending                       // Enable-transmit waits for token.
);

  // Address decode shared by read and write paths.
  // mapped() feeds the error flag.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `TNSD_OFF_STATUS) | hit(a, `TNSD_OFF_DIAG) | hit(a, `TNSD_OFF_CMD) |
             hit(a, `TNSD_OFF_MASK) | hit(a, `TNSD_OFF_NODE_ID) | hit(a, `TNSD_OFF_TENT_ID) |
             hit(a, `TNSD_OFF_NEXT_ID) | hit(a, `TNSD_OFF_CTRL);
  endfunction

  // Bus decode strobes.
  logic access_w;
  logic access_r;
  logic setup;
  logic cmd_wr;
  logic clr_flags;
  logic en_tx_cmd;
  logic en_rx_cmd;
  logic dis_tx_cmd;
  logic dis_rx_cmd;
  logic node_zero_wr;
  logic diag_rd;
  logic next_rd;

  // Line input and counters.
  logic rx_sync1_q;
  logic rx_sync2_q;
  logic [14:0] idle_cnt_q;
  logic idle_expire;
  logic [7:0] nak_cnt_q;
  logic [7:0] nak_limit;
  logic nak_hit;

  // Status flags and token waits.
  logic reset_flag_q;
  logic rebuild_q;
  logic tx_acked_flag_q;
  logic tx_available_flag_q;
  logic rx_inh_q;
  logic dis_tx_pend_q;
  logic dis_rx_pend_q;
  logic tx_pend_q;

  // Diagnostic flags.
  logic self_caused_rebuild_flag_q;
  logic duplicate_node_id_flag_q;
  logic receive_activity_flag_q;
  logic token_seen_q;
  logic excessive_nak_flag_q;
  logic tentative_id_match_flag_q;
  logic next_id_changed_flag_q;

  // Software registers.
  logic [7:0] interrupt_mask_register_q;
  logic [7:0] node_id_q;
  logic [7:0] tent_id_q;
  logic [7:0] next_id_q;
  logic [7:0] ctrl_q;

  // Read path and interrupt.
  logic [7:0] status_v;
  logic [7:0] diag_v;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic irq_q;
  logic [7:0] diag_clr;
  logic next_stale_q;

  // Zero wait states: the answer comes in the first access cycle.
  // So read data is latched at setup.
  assign setup = psel & ~penable;
  assign access_w = psel & penable & pwrite;
  assign access_r = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Write and read side effect strobes, all taken at the access edge.
  assign cmd_wr = access_w & hit(paddr, `TNSD_OFF_CMD);
  assign clr_flags = cmd_wr & (pwdata[2:0] == `TNSD_CMD_CLR_FLAGS);
  // Bit 7 must be clear.
  assign en_tx_cmd = cmd_wr & (pwdata[2:0] == `TNSD_CMD_EN_TX) & ~pwdata[7];
  assign en_rx_cmd = cmd_wr & (pwdata[2:0] == `TNSD_CMD_EN_RX);
  assign dis_tx_cmd = cmd_wr & (pwdata[7:0] == `TNSD_CMD_DIS_TX);
  assign dis_rx_cmd = cmd_wr & (pwdata[7:0] == `TNSD_CMD_DIS_RX);
  assign node_zero_wr = access_w & hit(paddr, `TNSD_OFF_NODE_ID) & (pwdata[7:0] == 8'h00);
  assign diag_rd = access_r & hit(paddr, `TNSD_OFF_DIAG);
  assign next_rd = access_r & hit(paddr, `TNSD_OFF_NEXT_ID);

  // A read clears only the flags that it returned; an event
  // at the setup edge would otherwise be lost.
  assign diag_clr = diag_rd ? prdata_q[7:0] : 8'h00;

  // A next ID update at the setup edge is not in the read data,
  // so that read must leave the changed flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_stale_q <= 1'b0;
    end else if (setup) begin
      next_stale_q <= nxt.valid;
    end
  end

  // Receive line synchroniser; only the second stage is used.
  // The first stage may be metastable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync1_q <= 1'b0;
      rx_sync2_q <= 1'b0;
    end else begin
      rx_sync1_q <= receive_line_input;
      rx_sync2_q <= rx_sync1_q;
    end
  end

  // line idle timer: restarts on any activity and after each expiry.
  // Expiry restarts it, so a dead line sets it each period.
  assign idle_expire = (idle_cnt_q == 15'(IDLE_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 15'h0000;
    end else if (rx_sync2_q || idle_expire) begin
      idle_cnt_q <= 15'h0000;
    end else begin
      idle_cnt_q <= idle_cnt_q + 15'h0001;
    end
  end

  // NAK counter: a positive enquiry answer restarts the count.
  // A limit change acts at once on the running count.
  assign nak_limit = ctrl_q[0] ? `TNSD_NAK_LIMIT_SHORT : `TNSD_NAK_LIMIT_LONG;
  assign nak_hit = evt.nak_rx & (nak_cnt_q == nak_limit - 8'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_cnt_q <= 8'h00;
    end else if (evt.enq_ok || nak_hit) begin
      nak_cnt_q <= 8'h00;
    end else if (evt.nak_rx) begin
      nak_cnt_q <= nak_cnt_q + 8'h01;
    end
  end

  // Software registers: mask, IDs and control. Next ID follows the engine.
  // Control keeps only bit 0, the NAK limit select.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_mask_register_q <= `TNSD_RST_MASK;
      node_id_q <= `TNSD_RST_ID;
      tent_id_q <= `TNSD_RST_ID;
      ctrl_q <= `TNSD_RST_CTRL;
      next_id_q <= `TNSD_RST_ID;
    end else begin
      if (access_w && hit(paddr, `TNSD_OFF_MASK)) interrupt_mask_register_q <= pwdata[7:0];
      if (access_w && hit(paddr, `TNSD_OFF_NODE_ID)) node_id_q <= pwdata[7:0];
      if (access_w && hit(paddr, `TNSD_OFF_TENT_ID)) tent_id_q <= pwdata[7:0];
      if (access_w && hit(paddr, `TNSD_OFF_CTRL)) ctrl_q <= {7'h00, pwdata[0]};
      if (nxt.valid) next_id_q <= nxt.id;
    end
  end

  // Status flags. Everywhere a set in the same cycle beats a clear.
  // Reset leaves reset flag and available set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_flag_q <= 1'b1;
      rebuild_q <= 1'b0;
      tx_acked_flag_q <= 1'b0;
      tx_available_flag_q <= 1'b1;
    end else begin
      reset_flag_q <= (reset_flag_q & ~clr_flags) | evt.soft_reset | node_zero_wr;
      rebuild_q <= (rebuild_q & ~clr_flags) | idle_expire;
      tx_acked_flag_q <= (tx_acked_flag_q & ~en_tx_cmd) | (evt.ack_rx & ~evt.broadcast);
      // cleared at the token; set on last byte or disable.
      tx_available_flag_q <= (tx_available_flag_q & ~(tx_pend_q & evt.token_rx)) |
                             evt.last_byte_sent | (dis_tx_pend_q & evt.token_rx);
    end
  end

  // Pending commands wait for the next token. Disable cancels a pending enable.
  // A command in a token cycle waits for the next token.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend_q <= 1'b0;
      dis_tx_pend_q <= 1'b0;
      dis_rx_pend_q <= 1'b0;
    end else begin
      tx_pend_q <= en_tx_cmd | (tx_pend_q & ~evt.token_rx & ~dis_tx_cmd);
      dis_tx_pend_q <= dis_tx_cmd | (dis_tx_pend_q & ~evt.token_rx & ~en_tx_cmd);
      dis_rx_pend_q <= dis_rx_cmd | (dis_rx_pend_q & ~evt.token_rx & ~en_rx_cmd);
    end
  end

  // receiver inhibited from reset until enable-receive.
  // A stored packet or deferred disable sets it again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_inh_q <= 1'b1;
    end else begin
      rx_inh_q <= (rx_inh_q & ~en_rx_cmd) | evt.packet_stored | (dis_rx_pend_q & evt.token_rx);
    end
  end

  // Diagnostic flags; only excessive NAK waits for clear-flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_caused_rebuild_flag_q <= 1'b0;
      duplicate_node_id_flag_q <= 1'b0;
      receive_activity_flag_q <= 1'b0;
      token_seen_q <= 1'b0;
      excessive_nak_flag_q <= 1'b0;
      tentative_id_match_flag_q <= 1'b0;
      next_id_changed_flag_q <= 1'b0;
    end else begin
      self_caused_rebuild_flag_q <= (self_caused_rebuild_flag_q & ~diag_clr[`TNSD_DG_SELF_REBUILD]) |
        evt.lost_token_to;
      // duplicate match; read clears, on line token sets.
      // Off line only a true duplicate sets it.
      duplicate_node_id_flag_q <= (duplicate_node_id_flag_q & ~diag_clr[`TNSD_DG_DUP_ID]) |
        (tok.seen & tok.response & tok.zeros_ok & (tok.dest_id1 == node_id_q) &
         (tok.dest_id2 == node_id_q)) | (evt.on_line & evt.token_rx);
      // logic one activity on the line.
      receive_activity_flag_q <= (receive_activity_flag_q & ~diag_clr[`TNSD_DG_RX_ACT]) |
        rx_sync2_q;
      token_seen_q <= (token_seen_q & ~diag_clr[`TNSD_DG_TOKEN]) |
        (tok.seen & tok.from_other);
      excessive_nak_flag_q <= (excessive_nak_flag_q & ~clr_flags) | nak_hit;
      // only the first destination ID is compared.
      tentative_id_match_flag_q <= (tentative_id_match_flag_q & ~diag_clr[`TNSD_DG_TENT]) |
        (tok.seen & tok.response & (tok.dest_id1 == tent_id_q));
      // next ID read clears, diagnostic read does not.
      next_id_changed_flag_q <= (next_id_changed_flag_q & ~(next_rd & ~next_stale_q)) | nxt.valid;
    end
  end

  // Read views of the two flag registers.
  always_comb begin
    status_v = 8'h00;
    status_v[`TNSD_ST_RX_INH] = rx_inh_q;
    status_v[`TNSD_ST_RESET] = reset_flag_q;
    status_v[`TNSD_ST_TEST] = 1'b0;
    status_v[`TNSD_ST_REBUILD] = rebuild_q;
    status_v[`TNSD_ST_TX_ACK] = tx_acked_flag_q;
    status_v[`TNSD_ST_TX_AVAIL] = tx_available_flag_q;

    // Bit 0 is reserved and reads zero.
    diag_v = 8'h00;
    diag_v[`TNSD_DG_SELF_REBUILD] = self_caused_rebuild_flag_q;
    diag_v[`TNSD_DG_DUP_ID] = duplicate_node_id_flag_q;
    diag_v[`TNSD_DG_RX_ACT] = receive_activity_flag_q;
    diag_v[`TNSD_DG_TOKEN] = token_seen_q;
    diag_v[`TNSD_DG_EXC_NAK] = excessive_nak_flag_q;
    diag_v[`TNSD_DG_TENT] = tentative_id_match_flag_q;
    diag_v[`TNSD_DG_NEXT_CHG] = next_id_changed_flag_q;
  end

  // Read mux; the command register is write only and reads zero.
  // Unmapped offsets read zero as well.
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      `TNSD_OFF_STATUS: rdata_d = {24'h000000, status_v};
      `TNSD_OFF_DIAG: rdata_d = {24'h000000, diag_v};
      `TNSD_OFF_MASK: rdata_d = {24'h000000, interrupt_mask_register_q};
      `TNSD_OFF_NODE_ID: rdata_d = {24'h000000, node_id_q};
      `TNSD_OFF_TENT_ID: rdata_d = {24'h000000, tent_id_q};
      `TNSD_OFF_NEXT_ID: rdata_d = {24'h000000, next_id_q};
      `TNSD_OFF_CTRL: rdata_d = {24'h000000, ctrl_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data and error are captured in the setup cycle so they come from flops.
  // Writes load zero, so no stale data shows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= ~mapped(paddr);
    end
  end

  // masked OR of interrupt flags, registered each clock.
  // Registered: one cycle late but glitch free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (tx_available_flag_q & interrupt_mask_register_q[`TNSD_MK_TX_AVAIL]) |
               (rebuild_q & interrupt_mask_register_q[`TNSD_MK_REBUILD]) |
               (excessive_nak_flag_q & interrupt_mask_register_q[`TNSD_MK_EXC_NAK]) |
               (next_id_changed_flag_q & interrupt_mask_register_q[`TNSD_MK_NEXT_CHG]) |
               (rx_inh_q & interrupt_mask_register_q[`TNSD_MK_RX_INH]);
    end
  end

  // Outputs come straight from flops.
  assign irq = irq_q;
  assign receiver_inhibited_flag = rx_inh_q;
  assign tx_pending = tx_pend_q;

endmodule // tnsd_flags
`default_nettype wire

// *** bench/tnsd_flags_monitor.sv ***
// Assertion checker for the status and diagnostic flag bank.
`timescale 1ns/10ps
`default_nettype none
module tnsd_flags_monitor #(
  parameter int unsigned IDLE_CYCLES = 16400
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire tnsd_pkg::tnsd_evt_t evt, // Engine events.
  input wire tnsd_pkg::tnsd_token_t tok, // Observed token.
  input wire tnsd_pkg::tnsd_next_t nxt, // Next ID update.
  input wire logic receive_line_input, // Receive line.
  input wire logic irq, // Interrupt request.
  input wire logic receiver_inhibited_flag, // Receiver inhibited.
  input wire logic tx_pending // Transmit waits for token.
);
  logic [7:0] mask_q; // Shadow of the interrupt mask.
  logic acc_w; // Write access phase.
  logic cmd_w; // Write access to the command register.
  assign acc_w = psel && penable && pwrite;
  assign cmd_w = acc_w && paddr == 8'h08;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow the mask so that a masked-off interrupt line can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 8'h00;
    end else if (acc_w && paddr == 8'h0C) begin
      mask_q <= pwdata[7:0];
    end
  end
  property p_ready; pready; endproperty
  property p_err; psel && !penable |=> pslverr == ($past(paddr) > 8'h1C || ($past(paddr) & 8'h03) != 8'h00);
  endproperty
  property p_upper; psel && !penable |=> prdata[31:8] == 24'h000000; endproperty
  property p_wr_zero; psel && !penable && pwrite |=> prdata == 32'h00000000; endproperty
  property p_test; psel && !penable && !pwrite && paddr == 8'h00 |=> !prdata[3]; endproperty
  property p_rx_en; cmd_w && pwdata[2:0] == 3'h4 && !evt.packet_stored && !evt.token_rx |=> !receiver_inhibited_flag;
  endproperty
  property p_rx_stored; evt.packet_stored |=> receiver_inhibited_flag; endproperty
  property p_tx_pend; cmd_w && pwdata[2:0] == 3'h3 && !pwdata[7] && !evt.token_rx |=> tx_pending; endproperty
  property p_irq_off; mask_q == 8'h00 |=> !irq; endproperty
  property p_rx_act; receive_line_input [*4] ##1 (psel && !penable && paddr == 8'h04) |=> prdata[5]; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
  a_test: assert property (p_test) else $error("test bit set");
  a_rx_en: assert property (p_rx_en) else $error("receiver still inhibited");
  a_rx_stored: assert property (p_rx_stored) else $error("receiver not inhibited");
  a_tx_pend: assert property (p_tx_pend) else $error("transmit not pending");
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all masked");
  a_rx_act: assert property (p_rx_act) else $error("receive activity missed");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_pend: cover property (tx_pending && evt.token_rx);
endmodule // tnsd_flags_monitor
bind tnsd_flags tnsd_flags_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) i_tnsd_flags_monitor (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .evt, .tok, .nxt, .receive_line_input, .irq,
  .receiver_inhibited_flag, .tx_pending);
`default_nettype wire

// *** bench/tnsd_host.sv ***
// Host software model: APB master that reads and polls the flag bank.
`timescale 1ns/10ps
`default_nettype none
module tnsd_host (
  input wire logic pclk, // Clock.
  output logic psel, // APB select.
  output logic penable, // APB enable.
  output logic pwrite, // APB direction.
  output logic [7:0] paddr, // APB address.
  output logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  output logic [32:0] rd_data, // Last transfer, error over data.
  output logic [15:0] rd_cnt // Count of reported reads.
);
  // Bus idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rd_data = 33'h000000000;
    rd_cnt = 16'h0000;
  end
  // One transfer; the request holds until pready is seen, and stale write data is inverted.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic note);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = {pslverr, prdata};
    if (!w && note) rd_cnt = rd_cnt + 16'h0001;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic poll_avail();
    xfer(1'b0, 8'h00, 32'h00000000, 1'b0);
    while (rd_data[0] !== 1'b1) xfer(1'b0, 8'h00, 32'h00000000, 1'b0);
  endtask
endmodule // tnsd_host
`default_nettype wire

// *** bench/tnsd_flags_tb.sv ***
// Self-checking testbench for the status and diagnostic flag bank.
`timescale 1ns/10ps
`default_nettype none
module tnsd_flags_tb;
  localparam int unsigned IDLE = 200;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  logic pclk, presetn, rxl, psel, penable, pwrite, pready, pslverr, irq, rif, txp;
  logic [7:0] paddr, node_id, tent_id, nxt_id;
  logic [31:0] pwdata, prdata;
  logic [32:0] rd_data;
  logic [15:0] rd_cnt, seen_cnt;
  tnsd_pkg::tnsd_evt_t evt;
  tnsd_pkg::tnsd_token_t tok;
  tnsd_pkg::tnsd_next_t nxt;
  int errors, n_tests;
  integer seed;
  logic [32:0] exp_q[$];
  logic [32:0] care_q[$];
  string name_q[$];
  tnsd_flags #(.IDLE_CYCLES(IDLE)) i_tnsd_flags (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .tok(tok), .nxt(nxt), .receive_line_input(rxl), .irq(irq), .receiver_inhibited_flag(rif), .tx_pending(txp));
  tnsd_host i_tnsd_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_data(rd_data), .rd_cnt(rd_cnt));
  // Free-running 25 MHz clock.
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Note the expected read result first, so the watcher can pair them in order.
  task automatic rd(input string what, input logic [7:0] a, input logic [32:0] e, input logic [32:0] c);
    name_q.push_back(what);
    exp_q.push_back(e);
    care_q.push_back(c);
    i_tnsd_host.xfer(1'b0, a, 32'h00000000, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_tnsd_host.xfer(1'b1, a, {24'h000000, d}, 1'b0);
  endtask
  // One-cycle event pulse; the trailing idle edge keeps repeated pulses apart.
  task automatic pulse(input int b);
    evt[b] <= 1'b1;
    @(posedge pclk);
    evt[b] <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic token(input logic oth, input logic [7:0] d1, input logic [7:0] d2, input logic z);
    tok <= '{1'b1, oth, d1, d2, z, 1'b1};
    @(posedge pclk);
    tok.seen <= 1'b0;
    @(posedge pclk);
  endtask
  // One transmit round, unicast or broadcast.
  task automatic tx_round(input logic bc);
    wr(8'h08, 8'h03);
    rd("acked clr", 8'h00, 33'h000000000, 33'h000000002);
    check("pending", 33'(txp), 33'h000000001);
    evt.broadcast <= bc;
    pulse(9);
    rd("avail clr", 8'h00, 33'h000000000, 33'h000000001);
    pulse(7);
    pulse(8);
    i_tnsd_host.poll_avail();
    rd("tx done", 8'h00, 33'({!bc, 1'b1}), 33'h000000003);
  endtask
  task automatic summarize();
    if (exp_q.size() != 0) errors++;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Each reported read is compared against the oldest note.
  always @(posedge pclk) begin
    if (rd_cnt != seen_cnt) begin
      seen_cnt = rd_cnt;
      check(name_q.pop_front(), rd_data & care_q.pop_front(), exp_q.pop_front());
    end
  end
  // Watchdog far beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    summarize();
  end
  initial begin
    seed = 32'h8b09;
    presetn = 1'b0;
    rxl = 1'b0;
    evt = '0;
    tok = '0;
    nxt = '0;
    errors = 0;
    n_tests = 0;
    seen_cnt = 16'h0000;
    node_id = {1'b1, 7'($random(seed))};
    tent_id = 8'($random(seed));
    nxt_id = 8'($random(seed));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("status rst", 8'h00, 33'h000000091, ALL);
    rd("diag rst", 8'h04, 33'h000000000, ALL);
    rd("unmapped", 8'h40, 33'h100000000, ALL);
    wr(8'h00, 8'hFF);
    wr(8'h08, 8'h06);
    rd("status clr", 8'h00, 33'h000000081, ALL);
    wr(8'h10, 8'h00);
    rd("node id zero", 8'h00, 33'h000000091, ALL);
    wr(8'h08, 8'h06);
    pulse(1);
    rd("soft reset", 8'h00, 33'h000000091, ALL);
    $display("test reset done");
    repeat (IDLE + 10) @(posedge pclk);
    rd("rebuild", 8'h00, 33'h000000004, 33'h000000004);
    wr(8'h0C, 8'h04);
    repeat (3) @(posedge pclk);
    check("irq on", 33'(irq), 33'h000000001);
    rxl <= 1'b1;
    repeat (4) @(posedge pclk);
    rd("rx activity", 8'h04, 33'h000000020, 33'h000000020);
    rxl <= 1'b0;
    wr(8'h08, 8'h06);
    rd("rebuild clr", 8'h00, 33'h000000000, 33'h000000004);
    repeat (3) @(posedge pclk);
    check("irq off", 33'(irq), 33'h000000000);
    $display("test rebuild done");
    tx_round(1'b0);
    tx_round(1'b1);
    evt.broadcast <= 1'b0;
    wr(8'h08, 8'h03);
    pulse(9);
    wr(8'h08, 8'h01);
    pulse(9);
    rd("avail dis", 8'h00, 33'h000000001, 33'h000000001);
    $display("test transmit done");
    wr(8'h10, node_id);
    wr(8'h14, tent_id);
    wr(8'h1C, 8'h01);
    pulse(5);
    token(1'b1, tent_id, 8'h00, 1'b0);
    token(1'b0, node_id, node_id, 1'b1);
    repeat (4) pulse(4);
    nxt <= '{1'b1, nxt_id};
    @(posedge pclk);
    nxt.valid <= 1'b0;
    rd("diag all", 8'h04, 33'h0000000DE, 33'h1FFFFFFDF);
    rd("diag kept", 8'h04, 33'h00000000A, ALL);
    rd("next id", 8'h18, 33'(nxt_id), ALL);
    rd("next clr", 8'h04, 33'h000000008, ALL);
    wr(8'h08, 8'h06);
    rd("nak clr", 8'h04, 33'h000000000, ALL);
    wr(8'h1C, 8'h00);
    pulse(3);
    repeat (127) pulse(4);
    rd("nak 127", 8'h04, 33'h000000000, 33'h000000008);
    pulse(4);
    rd("nak 128", 8'h04, 33'h000000008, 33'h000000008);
    evt.on_line <= 1'b1;
    pulse(9);
    rd("dup on line", 8'h04, 33'h000000040, 33'h000000040);
    evt.on_line <= 1'b0;
    $display("test diagnostic done");
    wr(8'h0C, 8'h80);
    repeat (3) @(posedge pclk);
    check("irq inhibit", 33'(irq), 33'h000000001);
    wr(8'h08, 8'h04);
    @(posedge pclk);
    check("rx enabled", 33'(rif), 33'h000000000);
    pulse(2);
    check("rx stored", 33'(rif), 33'h000000001);
    $display("test receive done");
    summarize();
  end
endmodule // tnsd_flags_tb
`default_nettype wire
